// ==== verilog/hcs_pkg.sv ====
/*
 Constants for the host channel 4 status flags block: bit positions,
 reset value and the I/O address bit that marks command or data.
 Assumes nothing of its surroundings.
*/
package hcs_pkg;
	// ----------------------------------------
	// Normal view field positions
	// ----------------------------------------
	localparam int BIT_CMD_DATA = 3;
	localparam int BIT_USER_2 = 2;
	localparam int BIT_IN_FULL = 1;
	localparam int BIT_OUT_FULL = 0;
	localparam logic [7:0] USER_MASK = 8'hf4;
	// ----------------------------------------
	// Bidirectional view field positions
	// ----------------------------------------
	localparam int BIT_BI_IN_FULL = 7;
	localparam int BIT_BI_OUT_FULL = 6;
	localparam int BIT_HOST_WMODE = 5;
	localparam int BIT_SLAVE_WMODE = 4;
	// ----------------------------------------
	// Misc
	// ----------------------------------------
	localparam int HOST_ADDR_CD_BIT = 2;
	localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

// ==== verilog/hcs_flag.sv ====
/*
 One sticky flag with set and clear terms, set winning over clear.
 Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
module hcs_flag (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Events
	input wire logic set,
	input wire logic clr,
	// State
	output logic q
);
	// Set wins so that an event in the clearing cycle is not lost
	always_ff @(posedge clock) begin
		if (rst) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule

// ==== verilog/hcs_status.sv ====
/*
 Channel 4 status register with normal and bidirectional views.
 Assumes host and slave access strobes are one-cycle pulses already
 synchronous to clock, produced by the host port and slave bus logic.
*/
// How it works
// R1: Bits 7..4 user bits, slave writes only
// R2: Bit 2 user bit, slave writes only
// R3: Host input write latches address bit 2
// R4: Input full set by host, cleared by slave
// R5: Input full flags raise slave interrupt request
// R6: Slave output write sets output full
// R7: Host read or slave zero clears output
// R8: Bidir bit 7: host last write, slave read
// R9: Bidir bit 6: slave last write, host clears
// R10: Host mode set on first write, idle slave
// R11: Slave mode set on first write, idle host
// R12: Slave mode cleared by host last read
// R13: Simultaneous first writes favour the host
// R14: Enable bit selects view at one location
// R15: Host status writes ignored; ones keep flags
`timescale 1ns/1ps
module hcs_status (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Mode
	input wire logic bidir_buffer_enable,
	// Host side events
	input wire logic host_wr_input,
	input wire logic [2:0] host_addr,
	input wire logic host_rd_output,
	input wire logic host_wr_first,
	input wire logic host_wr_last,
	input wire logic host_rd_last,
	input wire logic host_wr_status,
	// Slave side events
	input wire logic slave_rd_input,
	input wire logic slave_wr_output,
	input wire logic slave_wr_first,
	input wire logic slave_wr_last,
	input wire logic slave_rd_last,
	input wire logic slave_wr_status,
	input wire logic [7:0] slave_wdata,
	// Status out
	output logic [7:0] channel4_status_reg,
	output logic slave_irq_req
);
	logic [7:0] user_bits;
	logic cmd_data_flag;
	logic input_full_flag;
	logic output_full_flag;
	logic bidir_input_full_flag;
	logic bidir_output_full_flag;
	logic host_write_mode_flag;
	logic slave_write_mode_flag;
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Host status writes never reach any term below [R15]
	wire normal_wr = slave_wr_status && !bidir_buffer_enable;
	wire bidir_wr = slave_wr_status && bidir_buffer_enable;
	wire clr_out = host_rd_output
		|| (normal_wr && !slave_wdata[hcs_pkg::BIT_OUT_FULL]); // [R7] [R15]
	wire clr_bi_out = host_rd_last
		|| (bidir_wr && !slave_wdata[hcs_pkg::BIT_BI_OUT_FULL]); // [R9] [R15]
	wire clr_swm = host_rd_last
		|| (bidir_wr && !slave_wdata[hcs_pkg::BIT_SLAVE_WMODE]); // [R12] [R15]
	wire set_hwm = host_wr_first && !slave_write_mode_flag; // [R10] [R13]
	// Host takes the buffer in the same cycle, so the slave loses [R13]
	wire set_swm = slave_wr_first && !host_write_mode_flag && !host_wr_first; // [R11]
	// ----------------------------------------
	// User bits and command flag
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			user_bits <= hcs_pkg::STATUS_RESET;
			cmd_data_flag <= 1'b0;
		end else begin
			if (normal_wr) begin
				user_bits <= slave_wdata & hcs_pkg::USER_MASK; // [R1] [R2]
			end
			if (host_wr_input) begin
				cmd_data_flag <= host_addr[hcs_pkg::HOST_ADDR_CD_BIT]; // [R3]
			end
		end
	end
	// ----------------------------------------
	// Flags
	// ----------------------------------------
	hcs_flag u_ibf (.clock(clock), .rst(rst), .set(host_wr_input), // [R4]
		.clr(slave_rd_input), .q(input_full_flag));
	hcs_flag u_obf (.clock(clock), .rst(rst), .set(slave_wr_output), // [R6]
		.clr(clr_out), .q(output_full_flag));
	hcs_flag u_bibf (.clock(clock), .rst(rst), .set(host_wr_last), // [R8]
		.clr(slave_rd_last), .q(bidir_input_full_flag));
	hcs_flag u_bobf (.clock(clock), .rst(rst), .set(slave_wr_last), // [R9]
		.clr(clr_bi_out), .q(bidir_output_full_flag));
	hcs_flag u_hwm (.clock(clock), .rst(rst), .set(set_hwm), // [R10]
		.clr(slave_rd_last), .q(host_write_mode_flag));
	hcs_flag u_swm (.clock(clock), .rst(rst), .set(set_swm), // [R11]
		.clr(clr_swm), .q(slave_write_mode_flag));
	// ----------------------------------------
	// Read view
	// ----------------------------------------
	// Bits 3..0 of the bidirectional view are outside this block; read zero
	wire [7:0] normal_view = {user_bits[7:4], cmd_data_flag, user_bits[2],
		input_full_flag, output_full_flag};
	wire [7:0] bidir_view = {bidir_input_full_flag, bidir_output_full_flag,
		host_write_mode_flag, slave_write_mode_flag, 4'h0};
	assign channel4_status_reg = bidir_buffer_enable ? bidir_view : normal_view; // [R14]
	// Both input full flags request regardless of view
	assign slave_irq_req = input_full_flag || bidir_input_full_flag; // [R5]
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_cd;
		@(posedge clock) disable iff (rst)
		host_wr_input |=> cmd_data_flag == $past(host_addr[2]);
	endproperty
	a_cd: assert property (p_cd) else $error("cmd flag not captured"); // [R3]
	property p_ibf;
		@(posedge clock) disable iff (rst)
		host_wr_input |=> input_full_flag && slave_irq_req;
	endproperty
	a_ibf: assert property (p_ibf) else $error("input full not set"); // [R4]
	property p_irq;
		@(posedge clock) disable iff (rst)
		slave_irq_req == (input_full_flag || bidir_input_full_flag);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch"); // [R5]
	property p_obf;
		@(posedge clock) disable iff (rst)
		(host_rd_output && !slave_wr_output) |=> !output_full_flag;
	endproperty
	a_obf: assert property (p_obf) else $error("output full not cleared"); // [R7]
	property p_obf_set;
		@(posedge clock) disable iff (rst)
		slave_wr_output |=> output_full_flag;
	endproperty
	a_obf_set: assert property (p_obf_set) else $error("output full not set"); // [R6]
	property p_prio;
		@(posedge clock) disable iff (rst)
		(host_wr_first && slave_wr_first && !host_write_mode_flag
			&& !slave_write_mode_flag) |=> host_write_mode_flag && !slave_write_mode_flag;
	endproperty
	a_prio: assert property (p_prio) else $error("host priority lost"); // [R13]
	property p_swm_one;
		@(posedge clock) disable iff (rst)
		(bidir_wr && slave_wdata[4] && slave_write_mode_flag && !host_rd_last)
			|=> slave_write_mode_flag;
	endproperty
	a_swm_one: assert property (p_swm_one) else $error("write one cleared flag"); // [R15]
	property p_view;
		@(posedge clock) disable iff (rst)
		bidir_buffer_enable |-> channel4_status_reg[3:0] == 4'h0
			&& channel4_status_reg[7] == bidir_input_full_flag;
	endproperty
	a_view: assert property (p_view) else $error("wrong view"); // [R14]
	// A host first write in the same cycle sets host mode again, so it is left out
	property p_bibf;
		@(posedge clock) disable iff (rst)
		(slave_rd_last && !host_wr_last && !host_wr_first)
			|=> !bidir_input_full_flag && !host_write_mode_flag;
	endproperty
	a_bibf: assert property (p_bibf) else $error("bidir input not cleared"); // [R8]
	property p_user;
		@(posedge clock) disable iff (rst)
		normal_wr |=> user_bits[7:4] == $past(slave_wdata[7:4]);
	endproperty
	a_user: assert property (p_user) else $error("user bits not written"); // [R1]
	property p_user2;
		@(posedge clock) disable iff (rst)
		normal_wr |=> user_bits[2] == $past(slave_wdata[2]);
	endproperty
	a_user2: assert property (p_user2) else $error("user bit 2 not written"); // [R2]
	property p_user_hold;
		@(posedge clock) disable iff (rst)
		!normal_wr |=> $stable(user_bits);
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("user bits changed"); // [R15]
	property p_obf_zero;
		@(posedge clock) disable iff (rst)
		(normal_wr && !slave_wdata[0] && !slave_wr_output) |=> !output_full_flag;
	endproperty
	a_obf_zero: assert property (p_obf_zero) else $error("zero write kept output full"); // [R7]
	property p_bobf_set;
		@(posedge clock) disable iff (rst)
		slave_wr_last |=> bidir_output_full_flag;
	endproperty
	a_bobf_set: assert property (p_bobf_set) else $error("bidir output full not set"); // [R9]
	property p_bobf_clr;
		@(posedge clock) disable iff (rst)
		(host_rd_last && !slave_wr_last) |=> !bidir_output_full_flag;
	endproperty
	a_bobf_clr: assert property (p_bobf_clr) else $error("bidir output not cleared"); // [R9]
	property p_hwm_set;
		@(posedge clock) disable iff (rst)
		(host_wr_first && !slave_write_mode_flag) |=> host_write_mode_flag;
	endproperty
	a_hwm_set: assert property (p_hwm_set) else $error("host mode not set"); // [R10]
	property p_swm_set;
		@(posedge clock) disable iff (rst)
		(slave_wr_first && !host_wr_first && !host_write_mode_flag)
			|=> slave_write_mode_flag;
	endproperty
	a_swm_set: assert property (p_swm_set) else $error("slave mode not set"); // [R11]
	property p_swm_clr;
		@(posedge clock) disable iff (rst)
		(host_rd_last && !slave_wr_first) |=> !slave_write_mode_flag;
	endproperty
	a_swm_clr: assert property (p_swm_clr) else $error("slave mode not cleared"); // [R12]
	property p_excl;
		@(posedge clock) disable iff (rst)
		!(host_write_mode_flag && slave_write_mode_flag);
	endproperty
	a_excl: assert property (p_excl) else $error("both write modes set"); // [R13]
	property p_normal;
		@(posedge clock) disable iff (rst)
		!bidir_buffer_enable |-> channel4_status_reg[3] == cmd_data_flag
			&& channel4_status_reg[1:0] == {input_full_flag, output_full_flag};
	endproperty
	a_normal: assert property (p_normal) else $error("wrong normal view"); // [R14]
	c_cmd: cover property (@(posedge clock) host_wr_input && host_addr[2]);
	c_swm: cover property (@(posedge clock) slave_write_mode_flag && host_rd_last);
	c_prio: cover property (@(posedge clock) host_wr_first && slave_wr_first);
	c_bidir: cover property (@(posedge clock) bidir_buffer_enable && slave_irq_req);
endmodule

// ==== tb/hcs_host.sv ====
/*
 Host processor model: turns an I/O cycle code into one-cycle access strobes.
 Assumes the bench holds each code for exactly one clock.
*/
`timescale 1ns/1ps
module hcs_host (
	// Cycle request
	input wire logic [2:0] op,
	// Strobes to the port
	output logic wr_input,
	output logic [2:0] addr,
	output logic rd_output,
	output logic wr_first,
	output logic wr_last,
	output logic rd_last,
	output logic wr_status
);
	// Codes 1 and 2 write data and command; only address bit 2 differs
	assign wr_input = (op == 3'h1) || (op == 3'h2);
	assign addr = {op == 3'h2, 2'h0};
	assign rd_output = op == 3'h3;
	assign wr_first = op == 3'h4;
	assign wr_last = op == 3'h5;
	assign rd_last = op == 3'h6;
	assign wr_status = op == 3'h7;
endmodule

// ==== tb/hcs_bench.sv ====
/*
 Table-driven bench for the channel 4 status flags.
 Assumes the host model's strobes and a 40 MHz clock.
*/
`timescale 1ns/1ps
module host_channel4_status_flags_bench;
	logic clock = 1'h0, rst = 1'h1, bidir = 1'h0;
	logic [2:0] op = 3'h0;
	logic [5:0] sl = 6'h00;
	logic [7:0] wdata = 8'h00, status;
	logic [2:0] h_addr;
	logic h_wi, h_ro, h_wf, h_wl, h_rl, h_ws, irq;
	int bad_count = 0, checked = 0, cycles = 0;
	// Row: view, host code, slave strobes, slave data, status, irq
	logic [26:0] rows [21] = '{
		{1'h0, 3'h0, 6'h01, 8'hff, 8'hf4, 1'h0}, {1'h0, 3'h7, 6'h00, 8'h00, 8'hf4, 1'h0},
		{1'h0, 3'h2, 6'h00, 8'h00, 8'hfe, 1'h1}, {1'h0, 3'h0, 6'h20, 8'h00, 8'hfc, 1'h0},
		{1'h0, 3'h1, 6'h20, 8'h00, 8'hf6, 1'h1}, {1'h0, 3'h0, 6'h20, 8'h00, 8'hf4, 1'h0},
		{1'h0, 3'h0, 6'h10, 8'h00, 8'hf5, 1'h0}, {1'h0, 3'h3, 6'h00, 8'h00, 8'hf4, 1'h0},
		{1'h0, 3'h0, 6'h10, 8'h00, 8'hf5, 1'h0}, {1'h1, 3'h4, 6'h08, 8'h00, 8'h20, 1'h0},
		{1'h1, 3'h5, 6'h00, 8'h00, 8'ha0, 1'h1}, {1'h1, 3'h0, 6'h02, 8'h00, 8'h00, 1'h0},
		{1'h1, 3'h0, 6'h08, 8'h00, 8'h10, 1'h0}, {1'h1, 3'h4, 6'h00, 8'h00, 8'h10, 1'h0},
		{1'h1, 3'h0, 6'h04, 8'h00, 8'h50, 1'h0}, {1'h1, 3'h6, 6'h00, 8'h00, 8'h00, 1'h0},
		{1'h1, 3'h0, 6'h0c, 8'h00, 8'h50, 1'h0}, {1'h1, 3'h0, 6'h01, 8'hff, 8'h50, 1'h0},
		{1'h1, 3'h0, 6'h01, 8'h00, 8'h00, 1'h0}, {1'h0, 3'h0, 6'h00, 8'h00, 8'hf5, 1'h0},
		{1'h0, 3'h0, 6'h01, 8'h00, 8'h00, 1'h0}};
	hcs_host i_hcs_host (.op(op), .wr_input(h_wi), .addr(h_addr), .rd_output(h_ro),
		.wr_first(h_wf), .wr_last(h_wl), .rd_last(h_rl), .wr_status(h_ws));
	hcs_status i_hcs_status (.clock(clock), .rst(rst), .bidir_buffer_enable(bidir),
		.host_wr_input(h_wi), .host_addr(h_addr), .host_rd_output(h_ro),
		.host_wr_first(h_wf), .host_wr_last(h_wl), .host_rd_last(h_rl),
		.host_wr_status(h_ws), .slave_rd_input(sl[5]), .slave_wr_output(sl[4]),
		.slave_wr_first(sl[3]), .slave_wr_last(sl[2]), .slave_rd_last(sl[1]),
		.slave_wr_status(sl[0]), .slave_wdata(wdata), .channel4_status_reg(status),
		.slave_irq_req(irq));
	initial begin
		forever #12.5 clock = ~clock;
	end
	task automatic chk(input logic [7:0] e, input logic ei);
		checked++;
		if ({status, irq} !== {e, ei}) begin
			bad_count++;
			$display("BAD t=%0t got %h/%h want %h/%h", $time, status, irq, e, ei);
		end
	endtask
	task automatic end_sim;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Hang guard: the whole run needs well under a hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			end_sim;
		end
	end
	initial begin
		repeat (8) @(negedge clock);
		rst = 1'h0;
		chk(8'h00, 1'h0);
		foreach (rows[i]) begin
			{bidir, op, sl, wdata} = rows[i][26:9];
			@(posedge clock);
			#1 chk(rows[i][8:1], rows[i][0]);
			@(negedge clock);
		end
		// Reset in mid-run with input full pending
		{bidir, op, sl, wdata} = {1'h0, 3'h2, 6'h00, 8'h00};
		@(negedge clock);
		op = 3'h0;
		rst = 1'h1;
		repeat (2) @(negedge clock);
		rst = 1'h0;
		chk(8'h00, 1'h0);
		end_sim;
	end
endmodule
